// ---- dual_channel_pwm_generator_test.sv ----
// Self-checking bench for the two-channel PWM generator
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.svh"

module dual_channel_pwm_generator_test
	import pwm_pkg::*;
();
	localparam logic [9:0] ADDR_A = {`PWM_IDX_WIDTH_A, 2'b00};
	localparam logic [9:0] ADDR_B = {`PWM_IDX_WIDTH_B, 2'b00};
	localparam logic [9:0] ADDR_P = {`PWM_IDX_PRESCALE, 2'b00};
	logic        mclk_i;
	logic        rst_n_i;
	logic [9:0]  avs_address_i;
	logic        avs_read_i;
	logic        avs_write_i;
	logic [31:0] avs_writedata_i;
	logic [3:0]  avs_byteenable_i;
	wire  [31:0] avs_readdata_o;
	wire         avs_waitrequest_o;
	wire         pulse_out_n_a_o;
	wire         pulse_out_n_b_o;
	int          fail_count;
	int          n_tests;
	logic [31:0] rd_q[$];
	logic [31:0] seed;
	logic [9:0]  addrs[3];
	byte_t       vals[3];
	int          bad;

	pwm_top u_pwm_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .pulse_out_n_a_o(pulse_out_n_a_o),
		.pulse_out_n_b_o(pulse_out_n_b_o));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic stop_test;
		if (fail_count == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : stop_test

	// One Avalon access; holds everything until a rising edge sees waitrequest low
	task automatic bus(input logic [9:0] a, input logic rd, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		@(posedge mclk_i);
		avs_address_i <= a;
		avs_read_i <= rd;
		avs_write_i <= ~rd;
		avs_writedata_i <= d;
		avs_byteenable_i <= be;
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 40);
		if (n >= 40) check("waitrequest", 32'h1, 32'h0);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask : bus

	task automatic rd(input logic [9:0] a, input logic [31:0] exp);
		rd_q.push_back(exp);
		bus(a, 1'b1, 32'h0, 4'hF);
	endtask : rd

	task automatic wait_a(input logic lvl);
		int n;
		n = 0;
		do begin
			@(negedge mclk_i);
			n++;
		end while (pulse_out_n_a_o !== lvl && n < 3000);
		if (n >= 3000) check("pulse_a edge", 32'h0, 32'h1);
	endtask : wait_a

	// Programs both channels, resyncs, then times one low and one high phase of A
	task automatic pulse(input byte_t p, input byte_t wa, input byte_t wb);
		int lo;
		int hi;
		int f;
		bus(ADDR_P, 1'b0, {24'h0, p}, 4'h1);
		bus(ADDR_A, 1'b0, {24'h0, wa}, 4'h1);
		bus(ADDR_B, 1'b0, {24'h0, wb}, 4'h1);
		wait_a(1'b1);
		wait_a(1'b0);
		wait_a(1'b1);
		wait_a(1'b0);
		check("pulse_b at wrap", {31'h0, pulse_out_n_b_o}, {31'h0, wb == 8'h00});
		lo = 0;
		while (pulse_out_n_a_o === 1'b0 && lo < 3000) begin
			@(negedge mclk_i);
			lo++;
		end
		check("pulse_b at a rise", {31'h0, pulse_out_n_b_o}, {31'h0, wb <= wa});
		hi = 0;
		while (pulse_out_n_a_o === 1'b1 && hi < 3000) begin
			@(negedge mclk_i);
			hi++;
		end
		f = 2 * (int'(p) + 1);
		check("low time", lo, f * int'(wa));
		check("high time", hi, f * (255 - int'(wa)));
	endtask : pulse

	// ****************************************************************
	// Clock, read-data watcher, watchdog
	// ****************************************************************
	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end

	// Takes the oldest expected read value at the edge that answers a read
	always @(posedge mclk_i) begin
		if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
			if (rd_q.size() == 0) check("read queue", 32'h1, 32'h0);
			else check("readdata", avs_readdata_o, rd_q.pop_front());
		end
	end

	initial begin
		#200000;
		fail_count++;
		stop_test();
	end

	// Main sequence
	initial begin
		fail_count = 0;
		n_tests = 0;
		seed = 32'h885D;
		addrs = '{ADDR_A, ADDR_B, ADDR_P};
		rst_n_i = 1'b0;
		avs_address_i = 10'h000;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_writedata_i = 32'h0;
		avs_byteenable_i = 4'h0;
		repeat (8) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		@(negedge mclk_i);
		check("pulse_a reset", {31'h0, pulse_out_n_a_o}, 32'h1);
		for (int i = 0; i < 3; i++) rd(addrs[i], 32'h0);
		rd(10'h000, 32'h0);
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			vals[i] = seed[7:0];
			bus(addrs[i], 1'b0, seed, 4'h1);
			rd(addrs[i], {24'h0, vals[i]});
		end
		// Lane 0 disabled and unmapped writes must leave registers alone
		bus(ADDR_A, 1'b0, ~seed, 4'hE);
		bus(10'h3FC, 1'b0, seed, 4'hF);
		rd(ADDR_A, {24'h0, vals[0]});
		rd(10'h3FC, 32'h0);
		bus(ADDR_P, 1'b0, 32'h0, 4'h1);
		bus(ADDR_A, 1'b0, 32'h0, 4'h1);
		bus(ADDR_B, 1'b0, 32'hFF, 4'h1);
		repeat (4) @(negedge mclk_i);
		bad = 0;
		repeat (600) begin
			@(negedge mclk_i);
			if (pulse_out_n_a_o !== 1'b1 || pulse_out_n_b_o !== 1'b0) bad++;
		end
		check("constant levels", bad, 32'h0);
		bus(ADDR_A, 1'b0, 32'hFF, 4'h1);
		bus(ADDR_B, 1'b0, 32'h0, 4'h1);
		repeat (4) @(negedge mclk_i);
		bad = 0;
		repeat (600) begin
			@(negedge mclk_i);
			if (pulse_out_n_a_o !== 1'b0 || pulse_out_n_b_o !== 1'b1) bad++;
		end
		check("swapped constant levels", bad, 32'h0);
		pulse(8'h00, 8'h01, 8'hFE);
		pulse(8'h01, 8'h80, 8'h40);
		pulse(8'h02, 8'hFE, 8'h00);
		// Second reset in mid-run clears the registers
		@(posedge mclk_i);
		rst_n_i <= 1'b0;
		@(negedge mclk_i);
		check("pulse_a in reset", {31'h0, pulse_out_n_a_o}, 32'h1);
		repeat (3) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		rd(ADDR_A, 32'h0);
		rd(ADDR_P, 32'h0);
		stop_test();
	end
endmodule : dual_channel_pwm_generator_test
`default_nettype wire

// ---- pwm_pkg.sv ----
// Types shared by the PWM timebase and the PWM top level
`default_nettype none
package pwm_pkg;

	typedef logic [7:0] byte_t;

	typedef enum logic [1:0] {
		SEL_WIDTH_A  = 2'b00,
		SEL_WIDTH_B  = 2'b01,
		SEL_PRESCALE = 2'b10,
		SEL_NONE     = 2'b11
	} reg_sel_e;

endpackage : pwm_pkg
`default_nettype wire

// ---- pwm_regs.svh ----
// Register indices, field positions, reset values and timing counts of the PWM block
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH

// ****************************************************************
// Register indices (byte address = 4 x index)
// ****************************************************************
`define PWM_IDX_WIDTH_A   8'hFC
`define PWM_IDX_WIDTH_B   8'hFD
`define PWM_IDX_PRESCALE  8'hFE

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define PWM_FIELD_MSB     7
`define PWM_RST_WIDTH     8'h00
`define PWM_RST_PRESCALE  8'h00
`define PWM_RDATA_UNMAP   32'h0000_0000

// ****************************************************************
// Timing counts
// ****************************************************************
`define PWM_CNT_LAST      8'hFE
`define PWM_CNT_FIRST     8'h00
`define PWM_WIDTH_FULL    8'hFF

`endif

// ---- pwm_timebase.sv ----
// Shared prescaler, divide-by-two stage and modulo-255 counter
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.svh"

module pwm_timebase
	import pwm_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  prescale_i,
	output logic             step_o,
	output logic [7:0]       count_o
);

	// ****************************************************************
	// State
	// ****************************************************************
	byte_t div_q, div_d;
	logic  half_q, half_d;
	byte_t cnt_q, cnt_d;
	logic  tick;

	// Prescaler wraps after prescale+1 cycles; a value lowered to or below div_q wraps at once
	assign tick   = (div_q >= prescale_i);
	// Counter moves on every second prescaler tick
	assign step_o = tick & half_q;
	assign count_o = cnt_q;

	// Next-state logic of divider and counter
	always_comb begin
		div_d  = tick ? 8'h00 : div_q + 8'h01;
		half_d = tick ? ~half_q : half_q;
		cnt_d  = cnt_q;
		if (step_o) begin
			cnt_d = (cnt_q >= `PWM_CNT_LAST) ? `PWM_CNT_FIRST : cnt_q + 8'h01;
		end
	end

	// Registers, cleared on reset
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_q  <= 8'h00;
			half_q <= 1'b0;
			cnt_q  <= `PWM_CNT_FIRST;
		end else begin
			div_q  <= div_d;
			half_q <= half_d;
			cnt_q  <= cnt_d;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_cnt_range;
		@(posedge mclk_i) disable iff (!rst_n_i)
		count_o <= `PWM_CNT_LAST;
	endproperty
	a_cnt_range: assert property (p_cnt_range) else $error("counter reached 255");

	property p_cnt_wrap;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(step_o && count_o == `PWM_CNT_LAST) |=> (count_o == `PWM_CNT_FIRST);
	endproperty
	a_cnt_wrap: assert property (p_cnt_wrap) else $error("counter did not wrap");

	property p_cnt_inc;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(step_o && count_o < `PWM_CNT_LAST) |=> (count_o == $past(count_o) + 8'h01);
	endproperty
	a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not step by one");

	property p_cnt_hold;
		@(posedge mclk_i) disable iff (!rst_n_i)
		!step_o |=> $stable(count_o);
	endproperty
	a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without step");

	property p_step_gap;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(step_o && prescale_i == 8'h00) |=> !step_o ##1 (step_o || prescale_i != 8'h00);
	endproperty
	a_step_gap: assert property (p_step_gap) else $error("step spacing wrong");

	property p_div_wrap;
		@(posedge mclk_i) disable iff (!rst_n_i)
		tick |=> (div_q == 8'h00);
	endproperty
	a_div_wrap: assert property (p_div_wrap) else $error("prescaler did not restart");

endmodule : pwm_timebase
`default_nettype wire

// ---- pwm_top.sv ----
// Two-channel PWM generator with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.svh"

module pwm_top
	import pwm_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic [9:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	output logic             pulse_out_n_a_o,
	output logic             pulse_out_n_b_o
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Output level of one channel: low while width exceeds counter
	function automatic logic pulse_level(input byte_t width, input byte_t cnt);
		pulse_level = !(width > cnt);
	endfunction : pulse_level

	// Register select from a byte address
	function automatic reg_sel_e decode(input logic [9:0] addr);
		case (addr[9:2])
			`PWM_IDX_WIDTH_A:  decode = SEL_WIDTH_A;
			`PWM_IDX_WIDTH_B:  decode = SEL_WIDTH_B;
			`PWM_IDX_PRESCALE: decode = SEL_PRESCALE;
			default:           decode = SEL_NONE;
		endcase
	endfunction : decode

	// ****************************************************************
	// Register slave
	// ****************************************************************
	byte_t       width_a_q, width_a_d;
	byte_t       width_b_q, width_b_d;
	byte_t       prescale_q, prescale_d;
	logic        ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic        req;
	logic        wr_en;
	reg_sel_e    sel;
	byte_t       count;
	logic        step;

	assign req               = avs_read_i | avs_write_i;
	assign sel               = decode(avs_address_i);
	assign wr_en             = ack_q & avs_write_i & avs_byteenable_i[0];
	assign avs_waitrequest_o = req & ~ack_q;   // One wait state per access
	assign avs_readdata_o    = rdata_q;

	// Next values of the bus handshake, read data and registers
	always_comb begin
		ack_d      = req & ~ack_q;
		rdata_d    = rdata_q;
		width_a_d  = width_a_q;
		width_b_d  = width_b_q;
		prescale_d = prescale_q;
		if (ack_d && avs_read_i) begin
			case (sel)
				SEL_WIDTH_A:  rdata_d = {24'h000000, width_a_q};
				SEL_WIDTH_B:  rdata_d = {24'h000000, width_b_q};
				SEL_PRESCALE: rdata_d = {24'h000000, prescale_q};
				default:      rdata_d = `PWM_RDATA_UNMAP;
			endcase
		end
		if (wr_en) begin
			case (sel)
				SEL_WIDTH_A:  width_a_d  = avs_writedata_i[`PWM_FIELD_MSB:0];
				SEL_WIDTH_B:  width_b_d  = avs_writedata_i[`PWM_FIELD_MSB:0];
				SEL_PRESCALE: prescale_d = avs_writedata_i[`PWM_FIELD_MSB:0];
				default:      ;
			endcase
		end
	end

	// Slave registers
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_q      <= 1'b0;
			rdata_q    <= 32'h0000_0000;
			width_a_q  <= `PWM_RST_WIDTH;
			width_b_q  <= `PWM_RST_WIDTH;
			prescale_q <= `PWM_RST_PRESCALE;
		end else begin
			ack_q      <= ack_d;
			rdata_q    <= rdata_d;
			width_a_q  <= width_a_d;
			width_b_q  <= width_b_d;
			prescale_q <= prescale_d;
		end
	end

	// ****************************************************************
	// Shared timebase and channel compare
	// ****************************************************************
	// One timebase feeds both channels
	pwm_timebase u_timebase (
		.mclk_i     (mclk_i),
		.rst_n_i    (rst_n_i),
		.prescale_i (prescale_q),
		.step_o     (step),
		.count_o    (count)
	);

	logic out_a_q, out_a_d;
	logic out_b_q, out_b_d;

	// Compare every cycle so new widths act on the next compare
	always_comb begin
		out_a_d = pulse_level(width_a_q, count);
		out_b_d = pulse_level(width_b_q, count);
	end

	// Output flops, high (inactive) during reset
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_a_q <= 1'b1;
			out_b_q <= 1'b1;
		end else begin
			out_a_q <= out_a_d;
			out_b_q <= out_b_d;
		end
	end

	assign pulse_out_n_a_o = out_a_q;
	assign pulse_out_n_b_o = out_b_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_out_low;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(width_a_q > count) |=> !pulse_out_n_a_o;
	endproperty
	a_out_low: assert property (p_out_low) else $error("channel A not low");

	property p_out_high;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(width_b_q <= count) |=> pulse_out_n_b_o;
	endproperty
	a_out_high: assert property (p_out_high) else $error("channel B not high");

	property p_zero_high;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(width_a_q == 8'h00)[*2] |-> pulse_out_n_a_o;
	endproperty
	a_zero_high: assert property (p_zero_high) else $error("zero width not high");

	property p_full_low;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(width_b_q == `PWM_WIDTH_FULL)[*2] |-> !pulse_out_n_b_o;
	endproperty
	a_full_low: assert property (p_full_low) else $error("full width not low");

	property p_same_phase;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(width_a_q == width_b_q)[*2] |-> (pulse_out_n_a_o == pulse_out_n_b_o);
	endproperty
	a_same_phase: assert property (p_same_phase) else $error("channels out of phase");

	property p_write_applies;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(wr_en && sel == SEL_PRESCALE) |=> (prescale_q == $past(avs_writedata_i[7:0]));
	endproperty
	a_write_applies: assert property (p_write_applies) else $error("prescale write lost");

	property p_wait_one;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(req && !ack_q) |=> !avs_waitrequest_o;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest held too long");

	property p_out_low_b;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(width_b_q > count) |=> !pulse_out_n_b_o;
	endproperty
	a_out_low_b: assert property (p_out_low_b) else $error("channel B not low");

	property p_out_high_a;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(width_a_q <= count) |=> pulse_out_n_a_o;
	endproperty
	a_out_high_a: assert property (p_out_high_a) else $error("channel A not high");

	property p_zero_high_b;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(width_b_q == 8'h00)[*2] |-> pulse_out_n_b_o;
	endproperty
	a_zero_high_b: assert property (p_zero_high_b) else $error("zero width B not high");

	property p_full_low_a;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(width_a_q == `PWM_WIDTH_FULL)[*2] |-> !pulse_out_n_a_o;
	endproperty
	a_full_low_a: assert property (p_full_low_a) else $error("full width A not low");

	property p_width_a_write;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(wr_en && sel == SEL_WIDTH_A) |=> (width_a_q == $past(avs_writedata_i[7:0]));
	endproperty
	a_width_a_write: assert property (p_width_a_write) else $error("width A write lost");

	property p_width_b_write;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(wr_en && sel == SEL_WIDTH_B) |=> (width_b_q == $past(avs_writedata_i[7:0]));
	endproperty
	a_width_b_write: assert property (p_width_b_write) else $error("width B write lost");

	// Writes with lane 0 off or to an unused index leave every register alone
	property p_refused_write;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(ack_q && avs_write_i && (!avs_byteenable_i[0] || sel == SEL_NONE))
			|=> ($stable(width_a_q) && $stable(width_b_q) && $stable(prescale_q));
	endproperty
	a_refused_write: assert property (p_refused_write) else $error("refused write changed a register");

	property p_unmapped_read;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(ack_d && avs_read_i && sel == SEL_NONE) |=> (avs_readdata_o == `PWM_RDATA_UNMAP);
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

endmodule : pwm_top
`default_nettype wire
